// ==== hw/pmim_params.svh ====
/*
 * Register offsets, reset values and field positions of the interrupt
 * mask logic. Assumes inclusion by bare name from the design files.
 */
`ifndef PMIM_PARAMS_SVH
`define PMIM_PARAMS_SVH

`define PMIM_GEN_FLAGS_ADDR 8'h01
`define PMIM_LS_FLAGS_ADDR 8'h02
`define PMIM_GEN_MASK_ADDR 8'h03
`define PMIM_LS_MASK_ADDR 8'h04
`define PMIM_MASK_RESET 8'h00
`define PMIM_FLAGS_RESET 8'h00
`define PMIM_UNMAPPED_DATA 8'h00
`define PMIM_SRC_COUNT 6
`define PMIM_BYTE_WIDTH 8

// General bank field positions.
`define PMIM_PROG_VOLTAGE_LOW_BIT 5
`define PMIM_LINE_DETECT_CHANGE_BIT 4
`define PMIM_BUTTON_CHANGE_BIT 3
`define PMIM_THERMAL_WARNING_BIT 2
`define PMIM_COIN_ACQ_DONE_BIT 1
`define PMIM_DEFAULT_PROG_DONE_BIT 0

// Load switch bank field positions.
`define PMIM_SW3_FAULT_BIT 5
`define PMIM_SW2_FAULT_BIT 4
`define PMIM_SW1_FAULT_BIT 3
`define PMIM_SW3_ILIM_BIT 2
`define PMIM_SW2_ILIM_BIT 1
`define PMIM_SW1_ILIM_BIT 0

`endif

// ==== hw/pmim_pkg.sv ====
/*
 * Types shared by the interrupt mask logic.
 * Assumes the parameter header is on the include path.
 */
`include "pmim_params.svh"

package pmim_pkg;
    typedef logic [`PMIM_BYTE_WIDTH-1:0] pmim_byte_t;
endpackage

// ==== hw/pmim_bank_if.sv ====
/*
 * Connection between the top module and one flag bank.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

interface pmim_bank_if #(parameter int W = 6);
    logic [W-1:0] event_in;
    logic [W-1:0] mask;
    logic clear;
    logic [W-1:0] flags;
    logic pending;

    modport bank (input event_in, input mask, input clear,
                  output flags, output pending);
    modport ctrl (output event_in, output mask, output clear,
                  input flags, input pending);
endinterface

`default_nettype wire

// ==== hw/pmim_flag_bank.sv ====
/*
 * One bank of sticky interrupt flags with a clear strobe and a mask.
 * Assumes events are one-cycle pulses from logic on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

module pmim_flag_bank #(
    parameter int W = 6
) (
    // Clock and reset.
    input wire logic clock,
    input wire logic rstn,
    // Bank connection.
    pmim_bank_if.bank bif
);
    logic [W-1:0] flags_r;
    logic [W-1:0] flags_nxt;

    // Flags latch whatever the mask says, and a new event beats the clear.
    assign flags_nxt = (bif.clear ? '0 : flags_r) | bif.event_in;
    assign bif.flags = flags_r;
    // Only unmasked flags count towards the interrupt.
    assign bif.pending = |(flags_r & ~bif.mask);

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            flags_r <= '0;
        end else begin
            flags_r <= flags_nxt;
        end
    end
endmodule

`default_nettype wire

// ==== hw/pmim_top.sv ====
/*
 * Interrupt mask logic: two flag banks, two mask registers, register
 * read and write port, and the open-drain active-low interrupt output.
 * Assumes the serial front end turns bus transfers into one-cycle read
 * and write strobes on the same clock, and that flag events come from
 * monitoring logic on that clock.
 */
// Behaviour
// - General mask at 0x03, reset 0x00, bits 7-6 read zero, 5-0 writable.
// - Load switch mask at 0x04, reset 0x00, bits 7-6 read zero.
// - Unmasked source event pulls the interrupt output low.
// - Masked source event has no effect on the interrupt output.
// - Masks gate only the output; flags still latch every event.
// - General mask bits: voltage low, line, button, thermal, coin, prog.
// - Load switch bits 5-3 mask switch three, two, one faults.
// - Load switch bits 2-0 mask switch three, two, one current limits.
// - General flags read-only at 0x01, reset 0x00, mask bit layout.
// - Load switch flags read-only at 0x02, faults 5-3, limits 2-0.
`timescale 1ns/1ps
`default_nettype none
`include "pmim_params.svh"

module pmim_top
    import pmim_pkg::*;
#(
    parameter int W = `PMIM_SRC_COUNT
) (
    // Clock and reset.
    input wire logic clock,
    input wire logic rstn,
    // Source events, one-cycle pulses.
    input wire logic [W-1:0] general_event,
    input wire logic [W-1:0] load_switch_event,
    // Register port.
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // Open-drain interrupt pin.
    output logic irq_out_n,
    output logic irq_oe_n
);
    localparam int PAD = `PMIM_BYTE_WIDTH - W;

    if (W < 1 || W > 7) begin : g_bad_width
        $error("pmim_top: W must lie between 1 and 7");
    end

    ////////////////////////////////////////////////////////////////////////
    // Address decode and mask registers.

    pmim_bank_if #(.W(W)) gen_if ();
    pmim_bank_if #(.W(W)) ls_if ();

    logic [W-1:0] general_irq_mask_r;
    logic [W-1:0] general_irq_mask_nxt;
    logic [W-1:0] load_switch_irq_mask_r;
    logic [W-1:0] load_switch_irq_mask_nxt;
    pmim_byte_t reg_rdata_r;
    pmim_byte_t reg_rdata_nxt;
    logic irq_n_r;
    logic irq_n_nxt;

    wire sel_gen_flags = reg_addr == `PMIM_GEN_FLAGS_ADDR;
    wire sel_ls_flags = reg_addr == `PMIM_LS_FLAGS_ADDR;
    wire sel_gen_mask = reg_addr == `PMIM_GEN_MASK_ADDR;
    wire sel_ls_mask = reg_addr == `PMIM_LS_MASK_ADDR;

    // Writes land only in the writable low bits; flag offsets ignore them.
    assign general_irq_mask_nxt = (reg_wr && sel_gen_mask) ?
        reg_wdata[W-1:0] : general_irq_mask_r;
    assign load_switch_irq_mask_nxt = (reg_wr && sel_ls_mask) ?
        reg_wdata[W-1:0] : load_switch_irq_mask_r;

    // Reserved upper bits read as zero, unmapped offsets read as zero.
    wire [7:0] rd_gen_flags = {{PAD{1'b0}}, gen_if.flags};
    wire [7:0] rd_ls_flags = {{PAD{1'b0}}, ls_if.flags};
    wire [7:0] rd_gen_mask = {{PAD{1'b0}}, general_irq_mask_r};
    wire [7:0] rd_ls_mask = {{PAD{1'b0}}, load_switch_irq_mask_r};
    wire [7:0] rd_mux = sel_gen_flags ? rd_gen_flags :
                        sel_ls_flags ? rd_ls_flags :
                        sel_gen_mask ? rd_gen_mask :
                        sel_ls_mask ? rd_ls_mask :
                        `PMIM_UNMAPPED_DATA;
    assign reg_rdata_nxt = reg_rd ? rd_mux : reg_rdata_r;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            general_irq_mask_r <= W'(`PMIM_MASK_RESET);
            load_switch_irq_mask_r <= W'(`PMIM_MASK_RESET);
            reg_rdata_r <= `PMIM_UNMAPPED_DATA;
        end else begin
            general_irq_mask_r <= general_irq_mask_nxt;
            load_switch_irq_mask_r <= load_switch_irq_mask_nxt;
            reg_rdata_r <= reg_rdata_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Flag banks, cleared by reading them.

    assign gen_if.event_in = general_event;
    assign gen_if.mask = general_irq_mask_r;
    assign gen_if.clear = reg_rd && sel_gen_flags;
    assign ls_if.event_in = load_switch_event;
    assign ls_if.mask = load_switch_irq_mask_r;
    assign ls_if.clear = reg_rd && sel_ls_flags;

    pmim_flag_bank #(.W(W)) u_gen_bank (
        .clock(clock),
        .rstn(rstn),
        .bif(gen_if.bank)
    );

    pmim_flag_bank #(.W(W)) u_ls_bank (
        .clock(clock),
        .rstn(rstn),
        .bif(ls_if.bank)
    );

    ////////////////////////////////////////////////////////////////////////
    // Interrupt pin: registered, driven low in the cycle after an unmasked flag stands.

    assign irq_n_nxt = !(gen_if.pending || ls_if.pending);

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            irq_n_r <= 1'b1;
        end else begin
            irq_n_r <= irq_n_nxt;
        end
    end

    assign irq_out_n = irq_n_r;
    assign irq_oe_n = irq_n_r;
    assign reg_rdata = reg_rdata_r;

    ////////////////////////////////////////////////////////////////////////
    // Assertions.

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    gen_mask_write_a: assert property (
        reg_wr && sel_gen_mask |=>
        general_irq_mask_r == $past(reg_wdata[W-1:0]))
        else $error("general mask did not take written value");

    ls_mask_write_a: assert property (
        reg_wr && sel_ls_mask |=>
        load_switch_irq_mask_r == $past(reg_wdata[W-1:0]))
        else $error("load switch mask did not take written value");

    unmasked_irq_low_a: assert property (
        (general_event[`PMIM_THERMAL_WARNING_BIT] &&
         !general_irq_mask_r[`PMIM_THERMAL_WARNING_BIT] &&
         !general_irq_mask_nxt[`PMIM_THERMAL_WARNING_BIT])
        |=> ##1 !irq_out_n)
        else $error("unmasked event did not pull interrupt low");

    masked_no_irq_a: assert property (
        !gen_if.pending && !ls_if.pending |=> irq_out_n)
        else $error("interrupt low with no unmasked flag");

    flag_latch_a: assert property (
        load_switch_event[`PMIM_SW3_FAULT_BIT] |=>
        ls_if.flags[`PMIM_SW3_FAULT_BIT])
        else $error("event lost regardless of mask");

    gen_flag_read_a: assert property (
        reg_rd && sel_gen_flags |=>
        reg_rdata == {{PAD{1'b0}}, $past(gen_if.flags)})
        else $error("general flag read wrong");

    ls_flag_clear_a: assert property (
        reg_rd && sel_ls_flags && load_switch_event == '0 |=>
        ls_if.flags == '0)
        else $error("load switch flags not cleared by read");

    irq_release_a: assert property (
        !irq_out_n && !gen_if.pending && !ls_if.pending |=> irq_out_n)
        else $error("interrupt not released after flags cleared");

    reserved_zero_a: assert property (
        reg_rdata[7:W] == '0)
        else $error("reserved bits read nonzero");

    sw_ilim_mask_a: assert property (
        ls_if.flags[`PMIM_SW1_ILIM_BIT] &&
        !load_switch_irq_mask_r[`PMIM_SW1_ILIM_BIT] |=> !irq_out_n)
        else $error("unmasked current limit flag not asserting interrupt");

    irq_assert_c: cover property (irq_out_n ##1 !irq_out_n);
    masked_event_c: cover property (
        general_event != '0 && (general_event & ~general_irq_mask_r) == '0);
    read_clear_c: cover property (!irq_out_n ##1 gen_if.clear ##2 irq_out_n);
    set_wins_c: cover property (ls_if.clear && load_switch_event != '0);
endmodule

`default_nettype wire

// ==== test/pmim_host_model.sv ====
/*
 * Host side of the register port: one-cycle write and read strobes.
 * Assumes the design samples them on the rising edge of clock.
 */
`timescale 1ns/1ps
`default_nettype none

module pmim_host_model (
    // Clock.
    input wire logic clock,
    // Register port.
    output logic [7:0] reg_addr,
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata
);
    initial begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 8'h00;
    end

    ////////////////////////////////////////////////////////////////////////
    // Released lines carry the inverse so that stale values never match.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clock);
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clock);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clock);
        reg_rd = 1'b0;
        reg_addr = ~a;
        @(negedge clock);
        d = reg_rdata;
    endtask
endmodule

`default_nettype wire

// ==== test/testbench.sv ====
/*
 * Self-checking bench of the interrupt mask logic.
 * Assumes the host model drives the register port at the falling edge.
 */
`timescale 1ns/1ps
`default_nettype none
`include "pmim_params.svh"
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin \
    n_errors++; $display("wrong value %s expected %h seen %h", nm, ex, got); \
    end end

module testbench;
    import pmim_pkg::*;
    typedef struct {
        pmim_byte_t addr;
        pmim_byte_t wdata;
        pmim_byte_t ex;
    } pmim_row_s;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic [5:0] general_event = 6'h00;
    logic [5:0] load_switch_event = 6'h00;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic reg_wr, reg_rd, irq_out_n, irq_oe_n;
    wire logic irq_pin;
    int n_errors = 0;
    int tests_run = 0;
    pmim_byte_t rv, fa, ma, bitv;
    pmim_row_s rows[7] = '{'{8'h03, 8'hff, 8'h3f}, '{8'h04, 8'hff, 8'h3f},
        '{8'h03, 8'h15, 8'h15}, '{8'h04, 8'h2a, 8'h2a},
        '{8'h01, 8'hff, 8'h00}, '{8'h02, 8'hff, 8'h00}, '{8'h10, 8'hff, 8'h00}};

    // Pull-up on the open-drain interrupt line.
    assign irq_pin = irq_oe_n ? 1'b1 : irq_out_n;
    always #2.5 clock = ~clock;

    pmim_top dut_u (.clock, .rstn, .general_event, .load_switch_event,
        .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
        .irq_out_n, .irq_oe_n);
    pmim_host_model host_u (.clock, .reg_addr, .reg_wr, .reg_rd,
        .reg_wdata, .reg_rdata);

    ////////////////////////////////////////////////////////////////////////
    task final_report;
        $display("errors %0d checks %0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // One-cycle event pulse, then two cycles for flag and pin to follow.
    task automatic pulse(input bit b, input int i);
        @(negedge clock);
        if (b) load_switch_event[i] = 1'b1;
        else general_event[i] = 1'b1;
        @(negedge clock);
        load_switch_event = 6'h00;
        general_event = 6'h00;
        repeat (2) @(negedge clock);
    endtask

    initial begin
        repeat (20000) @(posedge clock);
        n_errors++;
        final_report;
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge clock);
        @(negedge clock) rstn = 1'b1;
        `CHK("pin after reset", 1'b1, irq_pin)
        for (int a = 1; a < 5; a++) begin
            host_u.rd(8'(a), rv);
            `CHK("reset value", 8'h00, rv)
        end
        foreach (rows[k]) begin
            host_u.wr(rows[k].addr, rows[k].wdata);
            host_u.rd(rows[k].addr, rv);
            `CHK("register", rows[k].ex, rv)
        end
        host_u.wr(8'h03, 8'h00);
        host_u.wr(8'h04, 8'h00);
        for (int b = 0; b < 2; b++) begin
            for (int i = 0; i < 6; i++) begin
                fa = b ? 8'h02 : 8'h01;
                ma = b ? 8'h04 : 8'h03;
                bitv = 8'h01 << i;
                pulse(b, i);
                `CHK("pin unmasked", 1'b0, irq_pin)
                host_u.rd(fa, rv);
                `CHK("flag position", bitv, rv)
                `CHK("pin after clear", 1'b1, irq_pin)
                host_u.wr(ma, bitv);
                pulse(b, i);
                `CHK("pin masked", 1'b1, irq_pin)
                host_u.wr(ma, 8'h00);
                @(negedge clock);
                `CHK("pin on unmask", 1'b0, irq_pin)
                host_u.rd(fa, rv);
                `CHK("masked flag", bitv, rv)
                `CHK("pin released", 1'b1, irq_pin)
            end
        end
        // A read that meets a new event keeps the new flag.
        fork
            host_u.rd(8'h02, rv);
            pulse(1, 0);
        join
        `CHK("set wins read", 8'h00, rv)
        `CHK("set wins pin", 1'b0, irq_pin)
        host_u.rd(8'h02, rv);
        `CHK("set wins flag", 8'h01, rv)
        `CHK("set wins release", 1'b1, irq_pin)
        // Reset in mid-run returns masks, flags and pin to idle.
        host_u.wr(8'h03, 8'h3f);
        host_u.rd(8'h03, rv);
        `CHK("mask before reset", 8'h3f, rv)
        pulse(1, 1);
        `CHK("pin before reset", 1'b0, irq_pin)
        @(negedge clock) rstn = 1'b0;
        @(negedge clock) rstn = 1'b1;
        `CHK("pin after mid reset", 1'b1, irq_pin)
        host_u.rd(8'h03, rv);
        `CHK("mask after reset", 8'h00, rv)
        host_u.rd(8'h02, rv);
        `CHK("flags after reset", 8'h00, rv)
        final_report;
    end
endmodule

`default_nettype wire
